// ---- src/rtcit_pkg.sv ----
// Package with register map, field layout, reset values and modes of the interval timer
package rtcit_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_COUNT   = 8'h04;
    localparam logic [7:0]  ADDR_PERIOD  = 8'h08;
    localparam logic [7:0]  ADDR_STATUS  = 8'h0c;
    localparam logic [7:0]  ADDR_MASK    = 8'h10;

    // ------------------------------------------------------------------
    // Control register field positions
    // ------------------------------------------------------------------
    localparam int          BIT_RUN      = 15;
    localparam int          BIT_SIDL     = 13;
    localparam int          BIT_GATE     = 6;
    localparam int          BIT_PRE_HI   = 5;
    localparam int          BIT_PRE_LO   = 4;
    localparam int          BIT_SYNC     = 2;
    localparam int          BIT_SRC      = 1;

    // ------------------------------------------------------------------
    // Status and mask bit positions
    // ------------------------------------------------------------------
    localparam int          EVT_MATCH    = 0;
    localparam int          EVT_GFALL    = 1;
    localparam int          EVT_W        = 2;

    // ------------------------------------------------------------------
    // Reset values and prescaler terminal counts (divide minus one)
    // ------------------------------------------------------------------
    localparam logic [15:0] PERIOD_RST   = 16'hffff;
    localparam logic [7:0]  PRE_TERM_1   = 8'h00;
    localparam logic [7:0]  PRE_TERM_8   = 8'h07;
    localparam logic [7:0]  PRE_TERM_64  = 8'h3f;
    localparam logic [7:0]  PRE_TERM_256 = 8'hff;

    // Operating modes decoded from the control bits
    typedef enum logic [1:0] {
        MODE_TIMER,
        MODE_GATED,
        MODE_SYNC_CNT,
        MODE_ASYNC_CNT
    } rtcit_mode_t;

endpackage : rtcit_pkg

// ---- src/rtcit_timer.sv ----
// 16-bit interval timer with prescaler, gate, external count pin and APB registers
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// What this block does
// - A single 16-bit up counter serves as real-time-clock counter or interval timer/counter.
// - Source select, gate and sync bits pick timer, gated, sync counter or async counter mode.
// - Timer and gated modes count the cycle clock; both counter modes count the external pin.
// - Source select sits at control bit 1, sync at bit 2 and gate enable at bit 6.
// - The run bit at position 15 starts the counter when 1 and stops it when 0.
// - With stop-in-idle at bit 13 set the timer halts in idle, otherwise it keeps running.
// - Gate enable at bit 6 enables gated accumulation with the internal clock, ignored otherwise.
// - Prescale field bits 5-4 divides by 256, 64, 8 or 1 for codes 11, 10, 01, 00.
// - With the external source, sync bit 1 adds a resync flop after the prescaler, 0 skips it; the pin is always two-flop synced.
// - Source select 1 counts rising pin edges, 0 counts the internal cycle clock.
// - Resynchronisation of the external clock is applied to the prescaler output.
// - The timer may run from the low-power secondary crystal on the pin to keep real time.
// - Control bits 14, 12-7, 3 and 0 read as zero and ignore writes.
// ----------------------------------------------------------------------
module rtcit_timer
    import rtcit_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        idle_i,
    input  wire logic        external_count_pin_i,
    input  wire logic        gate_pin_i,
    output logic      [15:0] count_o,
    output logic             irq_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        run_bit;
        logic        stop_in_idle_bit;
        logic        gate_enable_bit;
        logic [1:0]  prescale_select;
        logic        external_sync_bit;
        logic        clock_source_select;
        logic [15:0] count;
        logic [15:0] period;
        logic [7:0]  pre_cnt;
        logic [EVT_W-1:0] status;
        logic [EVT_W-1:0] mask;
        logic        pin_meta;
        logic        pin_sync;
        logic        pin_prev;
        logic        gate_meta;
        logic        gate_sync;
        logic        gate_prev;
        logic        resync;
        logic [31:0] rdata;
    } rtcit_state_t;

    rtcit_state_t st;
    rtcit_state_t next_st;

    logic        acc_wr;
    logic        setup_rd;
    logic        mapped;
    logic        running;
    logic        src_tick;
    logic        pre_tick;
    logic        cnt_tick;
    logic        gate_fall;
    logic [7:0]  pre_term;
    logic [15:0] ctrl_view;
    rtcit_mode_t mode;

    // ------------------------------------------------------------------
    // Mode decode and control view
    // ------------------------------------------------------------------
    // Gate is a don't-care with the pin source, sync with the internal one
    always_comb begin
        if (!st.clock_source_select) begin
            mode = st.gate_enable_bit ? MODE_GATED : MODE_TIMER;
        end else begin
            mode = st.external_sync_bit ? MODE_SYNC_CNT : MODE_ASYNC_CNT;
        end
    end

    // Unused positions are never stored, so they always read as zero
    always_comb begin
        ctrl_view           = 16'h0000;
        ctrl_view[BIT_RUN]  = st.run_bit;
        ctrl_view[BIT_SIDL] = st.stop_in_idle_bit;
        ctrl_view[BIT_GATE] = st.gate_enable_bit;
        ctrl_view[BIT_PRE_HI:BIT_PRE_LO] = st.prescale_select;
        ctrl_view[BIT_SYNC] = st.external_sync_bit;
        ctrl_view[BIT_SRC]  = st.clock_source_select;
    end

    // ------------------------------------------------------------------
    // Count path: source, prescaler, optional resync
    // ------------------------------------------------------------------
    // Prescale terminal count per select code
    always_comb begin
        case (st.prescale_select)
            2'b11:   pre_term = PRE_TERM_256;
            2'b10:   pre_term = PRE_TERM_64;
            2'b01:   pre_term = PRE_TERM_8;
            default: pre_term = PRE_TERM_1;
        endcase
    end

    // Idle only halts the timer when software asked for it
    assign running = st.run_bit && !(st.stop_in_idle_bit && idle_i);

    // Timer mode ticks every cycle, gated mode while the synchronised gate is high; pin source
    // ticks on a rising edge. The pin always passes two flops first, so a slow crystal on it needs no special path.
    always_comb begin
        case (mode)
            MODE_TIMER:  src_tick = 1'b1;
            MODE_GATED:  src_tick = st.gate_sync;
            default:     src_tick = st.pin_sync && !st.pin_prev;
        endcase
    end

    assign pre_tick = running && src_tick && (st.pre_cnt == pre_term);

    // Sync mode adds one flop on the prescaler output; async uses it directly
    assign cnt_tick = (mode == MODE_SYNC_CNT) ? st.resync : pre_tick;

    assign gate_fall = (mode == MODE_GATED) && running
                       && st.gate_prev && !st.gate_sync;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // Zero-wait slave: read data is captured in the setup cycle
    assign acc_wr   = psel_i && penable_i && pwrite_i;
    assign setup_rd = psel_i && !penable_i && !pwrite_i;

    always_comb begin
        if (paddr_i == ADDR_CTRL) begin
            mapped = 1'b1;
        end else if (paddr_i == ADDR_COUNT) begin
            mapped = 1'b1;
        end else if (paddr_i == ADDR_PERIOD) begin
            mapped = 1'b1;
        end else if (paddr_i == ADDR_STATUS) begin
            mapped = 1'b1;
        end else if (paddr_i == ADDR_MASK) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped;
    assign prdata_o  = st.rdata;
    assign count_o   = st.count;
    assign irq_o     = |(st.status & st.mask);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;

        // Two-flop synchronisers; the first stage feeds only the second
        next_st.pin_meta  = external_count_pin_i;
        next_st.pin_sync  = st.pin_meta;
        next_st.pin_prev  = st.pin_sync;
        next_st.gate_meta = gate_pin_i;
        next_st.gate_sync = st.gate_meta;
        next_st.gate_prev = st.gate_sync;

        // Prescaler only advances on source ticks while running
        if (!running) begin
            next_st.pre_cnt = 8'h00;
        end else if (src_tick) begin
            next_st.pre_cnt = pre_tick ? 8'h00 : st.pre_cnt + 8'h01;
        end
        next_st.resync = pre_tick && (mode == MODE_SYNC_CNT);

        // Counter with period wrap
        if (cnt_tick) begin
            if (st.count == st.period) begin
                next_st.count = 16'h0000;
            end else begin
                next_st.count = st.count + 16'h0001;
            end
        end

        // Read capture in setup phase
        if (setup_rd) begin
            if (paddr_i == ADDR_CTRL) begin
                next_st.rdata = {16'h0000, ctrl_view};
            end else if (paddr_i == ADDR_COUNT) begin
                next_st.rdata = {16'h0000, st.count};
            end else if (paddr_i == ADDR_PERIOD) begin
                next_st.rdata = {16'h0000, st.period};
            end else if (paddr_i == ADDR_STATUS) begin
                next_st.rdata = {30'h0, st.status};
            end else if (paddr_i == ADDR_MASK) begin
                next_st.rdata = {30'h0, st.mask};
            end else begin
                next_st.rdata = 32'h00000000;
            end
        end

        // Writes take effect at the access edge; a count write beats a tick
        if (acc_wr) begin
            if (paddr_i == ADDR_CTRL) begin
                next_st.run_bit             = pwdata_i[BIT_RUN];
                next_st.stop_in_idle_bit    = pwdata_i[BIT_SIDL];
                next_st.gate_enable_bit     = pwdata_i[BIT_GATE];
                next_st.prescale_select     = pwdata_i[BIT_PRE_HI:BIT_PRE_LO];
                next_st.external_sync_bit   = pwdata_i[BIT_SYNC];
                next_st.clock_source_select = pwdata_i[BIT_SRC];
            end else if (paddr_i == ADDR_COUNT) begin
                next_st.count = pwdata_i[15:0];
            end else if (paddr_i == ADDR_PERIOD) begin
                next_st.period = pwdata_i[15:0];
            end else if (paddr_i == ADDR_STATUS) begin
                next_st.status = st.status & ~pwdata_i[EVT_W-1:0];
            end else if (paddr_i == ADDR_MASK) begin
                next_st.mask = pwdata_i[EVT_W-1:0];
            end
        end

        // Events are set after the clear so a same-cycle event is never lost
        if (cnt_tick && (st.count == st.period)) begin
            next_st.status[EVT_MATCH] = 1'b1;
        end
        if (gate_fall) begin
            next_st.status[EVT_GFALL] = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st        <= '0;
            st.period <= PERIOD_RST;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    stopped_hold_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (!st.run_bit && !acc_wr && !st.resync) |=> $stable(st.count))
        else $error("count moved while stopped");

    idle_halt_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (st.stop_in_idle_bit && idle_i) |-> !pre_tick)
        else $error("prescaler ticked in idle with stop-in-idle set");

    gate_block_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (!st.clock_source_select && st.gate_enable_bit && !st.gate_sync) |-> !pre_tick)
        else $error("gated timer ticked with gate low");

    reserved_zero_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (setup_rd && paddr_i == ADDR_CTRL) |=> (st.rdata & 32'hffff5f89) == 32'h00000000)
        else $error("unused control bits read nonzero");

    prescale_term_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (running && st.prescale_select == 2'b01 && src_tick && st.pre_cnt == 8'h07
         && !acc_wr) |=> st.pre_cnt == 8'h00)
        else $error("divide by 8 did not wrap at seven");

    sync_delay_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (pre_tick && mode == MODE_SYNC_CNT) |=> st.resync)
        else $error("resync stage missed a prescaler tick");

    timer_step_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (mode == MODE_TIMER && running && st.prescale_select == 2'b00 && !acc_wr
         && st.count != st.period) |=> st.count == $past(st.count) + 16'h0001)
        else $error("timer mode did not count every cycle at 1:1");

    match_wrap_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (cnt_tick && st.count == st.period && !acc_wr)
        |=> (st.count == 16'h0000) && st.status[EVT_MATCH] && irq_o == st.mask[EVT_MATCH])
        else $error("period match did not wrap and flag");

    gate_event_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        gate_fall |=> st.status[EVT_GFALL])
        else $error("gate fall did not set its flag");

endmodule : rtcit_timer

// ---- dv/rtcit_pin_model.sv ----
// Model of the external count source and gate signal that feed the timer pins
`timescale 1ns/1ns
module rtcit_pin_model (
    input  wire logic core_clk_i,
    output logic      count_pin_o,
    output logic      gate_pin_o
);
    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    // Both lines start low, and the count source stands still between bursts
    initial begin
        count_pin_o = 1'b0;
        gate_pin_o  = 1'b0;
    end

    // Slow pulse burst, like a crystal far below the core rate.
    // The gap must be at least one cycle, or the high level never reaches the pin and edges are lost.
    task automatic send_pulses(input int n, input int gap);
        repeat (n) begin
            @(posedge core_clk_i);
            count_pin_o <= 1'b1;
            repeat (gap) @(posedge core_clk_i);
            count_pin_o <= 1'b0;
            repeat (gap) @(posedge core_clk_i);
        end
    endtask : send_pulses

    // Gate level changes land just after an edge
    task automatic set_gate(input logic v);
        @(posedge core_clk_i);
        gate_pin_o <= v;
    endtask : set_gate
endmodule : rtcit_pin_model

// ---- dv/rtc_capable_interval_timer_tb.sv ----
// Self-checking testbench of the interval timer: registers, modes, prescaler, events
`timescale 1ns/1ns
module rtc_capable_interval_timer_tb;
    import rtcit_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        rst_b_i    = 1'b0;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [7:0]  paddr      = 8'h00;
    logic [31:0] pwdata     = 32'h0;
    logic        idle       = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_pin;
    logic        gate_pin;
    logic [15:0] count;
    logic        irq;
    logic [31:0] seed       = 32'hf964c90e;
    int          num_errors = 0;
    int          n_compared = 0;

    // ------------------------------------------------------------------
    // Design, pin source, clock and reset
    // ------------------------------------------------------------------
    rtcit_timer uut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .idle_i(idle),
        .external_count_pin_i(ext_pin), .gate_pin_i(gate_pin), .count_o(count), .irq_o(irq));
    rtcit_pin_model u_src (.core_clk_i(core_clk_i), .count_pin_o(ext_pin), .gate_pin_o(gate_pin));

    always #5 core_clk_i = ~core_clk_i;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask : cmp

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Source ticks that survive the prescaler for a given run length
    function automatic int exp_ticks(input int cyc, input logic [1:0] ps);
        return cyc / ((ps == 2'b11) ? 256 : (ps == 2'b10) ? 64 : (ps == 2'b01) ? 8 : 1);
    endfunction : exp_ticks

    // One APB transfer; holds the request until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge core_clk_i);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, a, d, rd, e);
    endtask : wr

    task automatic chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        e;
        apb(1'b0, a, 32'h0, rd, e);
        cmp(what, exp, rd);
    endtask : chk

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic [31:0] rd;
        logic        e;
        logic [15:0] per;
        int          w;
        int          t;
        repeat (5) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        chk("ctrl reset", ADDR_CTRL, 32'h0);
        chk("period reset", ADDR_PERIOD, 32'h0000ffff);
        chk("count reset", ADDR_COUNT, 32'h0);
        wr(ADDR_CTRL, 32'hffffffff);
        chk("ctrl writable bits", ADDR_CTRL, 32'h0000a076);
        wr(ADDR_CTRL, 32'h0);
        apb(1'b0, 8'h14, 32'h0, rd, e);
        cmp("unmapped read", 32'h1, {31'h0, e});
        cmp("unmapped data", 32'h0, rd);
        // Timer, gated and idle runs with random length and period, prescale stepping with the loop index
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            per = {12'h0, r[3:0]};
            w = int'(r[13:5]);
            u_src.set_gate(r[17]);
            idle <= r[15];
            wr(ADDR_PERIOD, {16'h0, per});
            wr(ADDR_COUNT, 32'h0);
            wr(ADDR_STATUS, 32'h3);
            wr(ADDR_MASK, {31'h0, r[18]});
            wr(ADDR_CTRL, {16'h0, 1'b1, 1'b0, r[14], 6'h0, r[16], 2'(i), 4'h0});
            repeat (w) @(posedge core_clk_i);
            wr(ADDR_CTRL, 32'h0);
            t = ((r[14] && r[15]) || (r[16] && !r[17])) ? 0 : exp_ticks(w + 3, 2'(i));
            chk("count", ADDR_COUNT, t % (per + 1));
            cmp("count out", t % (per + 1), {16'h0, count});
            chk("status", ADDR_STATUS, {31'h0, t > per});
            cmp("irq", {31'h0, (t > per) && r[18]}, {31'h0, irq});
            wr(ADDR_STATUS, 32'h3);
            // The clear lands at the edge the task returns on; look once it has settled
            @(negedge core_clk_i);
            cmp("irq cleared", 32'h0, {31'h0, irq});
        end
        idle <= 1'b0;
        u_src.set_gate(1'b0);
        // Pin counting, synchronised and not; gate bit must be ignored
        for (int j = 0; j < 4; j++) begin
            r = rnd();
            wr(ADDR_PERIOD, 32'h0000ffff);
            wr(ADDR_COUNT, 32'h0);
            wr(ADDR_CTRL, {16'h0, 1'b1, 8'h0, r[0], 1'b0, j[1], 1'b0, j[0], 2'b10});
            u_src.send_pulses(9 + 8 * j, 3);
            repeat (12) @(posedge core_clk_i);
            wr(ADDR_CTRL, 32'h0);
            chk("pin count", ADDR_COUNT, exp_ticks(9 + 8 * j, {1'b0, j[1]}));
        end
        // Gate falling while running raises its event
        wr(ADDR_STATUS, 32'h3);
        wr(ADDR_MASK, 32'h2);
        u_src.set_gate(1'b1);
        wr(ADDR_CTRL, 32'h00008040);
        repeat (20) @(posedge core_clk_i);
        u_src.set_gate(1'b0);
        repeat (10) @(posedge core_clk_i);
        chk("gate fall", ADDR_STATUS, 32'h2);
        cmp("gate irq", 32'h1, {31'h0, irq});
        report_and_stop();
    end

    // Hang guard, far beyond the expected run length
    initial begin
        #900000;
        num_errors++;
        report_and_stop();
    end
endmodule : rtc_capable_interval_timer_tb
